// ===== dv/dma_far_side.sv
// Model of the serial peripheral and of memory behind the matrix.
// Assumes it shares ref_clk with the unit; slow adds memory wait.
`timescale 1ns/1ns
`default_nettype none
module dma_far_side (
  // Clock, reset, bench controls
  input wire         ref_clk, rst, rxGo, txGo, slow,
  // Peripheral and memory
  input wire         rxTake, txLoad, memReq,
  input wire  [31:0] memAddr,
  output logic       rxReady, txReady, memDone,
  output logic [31:0] rxData, memRdata
);
  logic [2:0] waitQ;
  always @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      {rxReady, txReady, memDone, waitQ} <= '0;
      rxData <= 32'h0;
      memRdata <= 32'h0;
    end
    else
    begin
      rxReady <= rxGo & ~rxTake;
      // Drop ready as the read completes, so a stale ready cannot start the next read
      txReady <= txGo & ~txLoad & ~memDone;
      // Data wanders whenever nothing is offered
      if (!rxReady)
        rxData <= rxData + 32'h9E3779B9;
      waitQ <= (memReq & ~memDone) ? waitQ + 3'h1 : 3'h0;
      memDone <= memReq & ~memDone & (waitQ >= {slow, 2'h1});
      memRdata <= (memReq & ~memDone) ? memAddr ^ 32'h5A5A5A5A : ~memRdata;
    end
endmodule
`default_nettype wire

// ===== dv/peripheral_dma_channel_regs_test.sv
// Self-checking bench for the peripheral DMA channel pair.
// Sole AHB-Lite master; far-side model answers memory and peripheral.
`timescale 1ns/1ns
`default_nettype none
module peripheral_dma_channel_regs_test;
  logic ref_clk, rst, hwrite, rxGo, txGo, slow;
  logic [1:0] htrans;
  logic [11:0] a;
  logic [1:0] sz;
  logic [31:0] haddr, hwdata, d, p;
  wire [31:0] hrdata, txData, memAddr, memWdata, rxData, memRdata;
  wire [1:0] memSize;
  wire hreadyout, hresp, rxTake, txLoad, memReq, memWrite, memDone, rxReady, txReady;
  wire rxEndFlag, rxBuffersFullFlag, txEndFlag, txBuffersEmptyFlag;
  wire hsel = 1'b1;
  wire hready = hreadyout;
  wire [2:0] hsize = 3'h2;
  int n_fail = 0, comparisons = 0, i, s;
  logic [31:0] rq[$];
  logic [32:0] mq[$];
  logic dph = 1'b0, dw = 1'b0;
  // half duplex from entry 6; transmit enable after receive enable leaves both set
  logic [23:0] tbl[12] = '{24'h001001, 24'h100101, 24'h002100, 24'h003100, 24'h200000,
    24'h000000, 24'h100100, 24'h001001, 24'h100101, 24'h002000, 24'h001001, 24'h200000};

  peripheral_dma_unit i_dut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxReady(rxReady), .rxData(rxData),
    .rxTake(rxTake), .txReady(txReady), .txData(txData), .txLoad(txLoad),
    .rxEndFlag(rxEndFlag), .rxBuffersFullFlag(rxBuffersFullFlag), .txEndFlag(txEndFlag),
    .txBuffersEmptyFlag(txBuffersEmptyFlag), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memSize(memSize), .memWdata(memWdata), .memDone(memDone),
    .memRdata(memRdata));
  dma_far_side i_far (
    .ref_clk(ref_clk), .rst(rst), .rxGo(rxGo), .txGo(txGo), .slow(slow),
    .rxTake(rxTake), .txLoad(txLoad), .memReq(memReq), .memAddr(memAddr),
    .rxReady(rxReady), .txReady(txReady), .memDone(memDone), .rxData(rxData),
    .memRdata(memRdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task bus(input logic [11:0] ad, input logic w, input logic [31:0] dat);
    haddr <= {20'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= dat;
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
  endtask

  task rd(input logic [11:0] ad, input logic [31:0] exp);
    rq.push_back(exp);
    bus(ad, 1'b0, 32'h0);
  endtask

  task wr(input logic [11:0] ad, input logic [31:0] dat);
    bus(ad, 1'b1, dat);
  endtask

  always @(posedge ref_clk)
  begin
    if (dph && hreadyout && !dw)
      chk(hrdata, rq.pop_front());
    if (dph && hreadyout)
      chk(33'(hresp), 33'h0);
    if (hreadyout)
    begin
      dph <= htrans[1];
      dw <= hwrite;
    end
    if (memReq && memDone)
    begin
      chk({memWrite, memAddr}, mq.pop_front());
      chk(33'(memSize), 33'(sz));
    end
  end

  initial
  begin
    void'($urandom(60348));
    {rst, htrans, hwrite, rxGo, txGo, slow, haddr, hwdata} = '0;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values, unmapped 0x130 included
    for (a = 12'h100; a < 12'h134; a += 12'h4)
      rd(a, 32'h0);
    for (a = 12'h100; a < 12'h120; a += 12'h4)
    begin
      d = $urandom;
      wr(a, d);
      rd(a, a[2] ? {16'h0, d[15:0]} : d);
    end
    for (i = 0; i < 12; i++)
    begin
      if (i == 6)
        wr(12'h12C, 32'h1);
      wr(12'h120, {20'h0, tbl[i][23:12]});
      rd(12'h124, {20'h0, tbl[i][11:0]});
    end
    wr(12'h108, d);
    rd(12'h100, d);
    wr(12'h12C, 32'h20);
    p = $urandom;
    p[1:0] = 2'h0;
    slow <= 1'b1;
    sz = 2'h2;
    wr(12'h108, p);
    wr(12'h10C, 32'h2);
    wr(12'h118, p + 32'h40);
    wr(12'h11C, 32'h1);
    mq = '{{1'b0, p}, {1'b0, p + 32'h4}, {1'b0, p + 32'h40}};
    wr(12'h120, 32'h100);
    txGo <= 1'b1;
    repeat (300) if (!txBuffersEmptyFlag) @(posedge ref_clk);
    chk(33'({txEndFlag, txBuffersEmptyFlag}), 33'h3);
    rd(12'h128, 32'h30);
    rd(12'h108, p + 32'h44);
    rd(12'h11C, 32'h0);
    wr(12'h120, 32'h200);
    txGo <= 1'b0;
    wr(12'h11C, 32'h3);
    rd(12'h128, 32'h0);
    wr(12'h114, 32'h0);
    for (s = 0; s < 3; s++)
    begin
      p = $urandom;
      slow <= s[0];
      sz = s[1:0];
      wr(12'h12C, {26'h0, s[1:0], 4'h0});
      wr(12'h100, p);
      wr(12'h104, 32'h2);
      mq = '{{1'b1, p}, {1'b1, p + (32'h1 << s)}};
      wr(12'h120, 32'h1);
      rxGo <= 1'b1;
      repeat (300) if (!rxBuffersFullFlag) @(posedge ref_clk);
      chk(33'({rxEndFlag, rxBuffersFullFlag}), 33'h3);
      rxGo <= 1'b0;
      wr(12'h120, 32'h2);
      rd(12'h100, p + (32'h2 << s));
    end
    chk(33'(mq.size()), 33'h0);
    report_and_stop;
  end

  initial
  begin
    #40000;
    n_fail++;
    report_and_stop;
  end
endmodule

bind peripheral_dma_unit peripheral_dma_unit_sva i_sva (
  .ref_clk(ref_clk), .rst(rst), .hreadyout(hreadyout), .rxReady(rxReady),
  .rxTake(rxTake), .txLoad(txLoad), .memReq(memReq), .memWrite(memWrite),
  .memDone(memDone), .txEndFlag(txEndFlag), .rxEndFlag(rxEndFlag), .rxData(rxData),
  .memWdata(memWdata), .memRdata(memRdata), .txData(txData), .memAddr(memAddr));
`default_nettype wire

// ===== dv/peripheral_dma_unit_sva.sv
// Checker for the peripheral DMA unit, bound to its top ports.
// Assumes one clock domain, reset asynchronous and active high.
`timescale 1ns/1ns
`default_nettype none
module peripheral_dma_unit_sva (
  // Clock, reset and bus
  input wire        ref_clk, rst, hreadyout,
  // Channels and memory
  input wire        rxReady, rxTake, txLoad, memReq, memWrite, memDone,
  input wire        txEndFlag, rxEndFlag,
  input wire [31:0] rxData, memWdata, memRdata, txData, memAddr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rx_start; !rxTake ##1 rxTake; endsequence
  sequence s_done; memReq && memDone; endsequence

  a_take_after_ready: assert property (s_rx_start |-> $past(rxReady) && memReq && memWrite)
    else $error("receive take without ready or write");
  a_take_data: assert property (rxTake |-> memWdata == rxData)
    else $error("receive data not passed to memory");
  a_take_pulse: assert property (rxTake |=> !rxTake)
    else $error("receive take longer than one cycle");
  a_load_from_mem: assert property ((s_done ##0 !memWrite) |=> txLoad && txData == $past(memRdata))
    else $error("transmit load missing or wrong data");
  a_load_cause: assert property (txLoad |-> $past(memDone && !memWrite))
    else $error("transmit load without memory read");
  a_req_holds: assert property (memReq && !memDone |=> memReq && $stable(memAddr))
    else $error("memory request dropped or address moved");
  a_tx_end_cause: assert property ($rose(txEndFlag) |-> $past(memDone))
    else $error("transmit end flag without access");
  a_rx_end_cause: assert property ($rose(rxEndFlag) |-> $past(memDone))
    else $error("receive end flag without access");
  a_bus_wait: assert property (!hreadyout |=> hreadyout)
    else $error("bus wait longer than one cycle");
endmodule
`default_nettype wire

// ===== hw/peripheral_dma_consts.vh
// Offsets, field positions and codes of the peripheral DMA channel pair.
// Definitions only; included by peripheral_dma_unit.v.
`ifndef PERIPHERAL_DMA_CONSTS_VH
`define PERIPHERAL_DMA_CONSTS_VH

`define OFF_RX_PTR      12'h100
`define OFF_RX_CNT      12'h104
`define OFF_TX_PTR      12'h108
`define OFF_TX_CNT      12'h10C
`define OFF_RX_NPTR     12'h110
`define OFF_RX_NCNT     12'h114
`define OFF_TX_NPTR     12'h118
`define OFF_TX_NCNT     12'h11C
`define OFF_CTRL        12'h120
`define OFF_STAT        12'h124
`define OFF_FLAGS       12'h128
`define OFF_CONFIG      12'h12C

`define CTRL_RX_EN      0
`define CTRL_RX_DIS     1
`define CTRL_TX_EN      8
`define CTRL_TX_DIS     9

`define FLAG_RX_END     0
`define FLAG_RX_FULL    1
`define FLAG_TX_END     4
`define FLAG_TX_EMPTY   5

`define CFG_HALF_DUPLEX 0
`define CFG_SIZE_LO     4
`define CFG_SIZE_HI     5

`define SIZE_BYTE       2'h0
`define SIZE_HALF       2'h1
`define SIZE_WORD       2'h2

`define CNT_W           16
`define RESET_WORD      32'h00000000

`endif

// ===== hw/peripheral_dma_unit.v
// Peripheral DMA channel pair: registers on AHB-Lite, a receive and a
// transmit channel, and a simple single-word memory master port.
// Assumes the serial peripheral and memory port share ref_clk.
//
// Behaviour
// - Half duplex shares one pointer/counter set
// - Zero count halts, nonzero runs if enabled
// - Read/write next receive pointer register
// - Read/write 16-bit next receive counter
// - Read/write next transmit pointer register
// - Read/write 16-bit next transmit counter
// - Bit 0 enables receive unless disable set
// - Bit 1 disables receive requests
// - Bit 8 enables transmit requests
// - Bit 9 disables transmit requests
// - Half duplex: receive enable stops transmit
// - Half duplex: transmit enable needs no receive enable
// - Half duplex: receive disable stops transmit too
// - Half duplex: transmit disable stops receive too unless bit 0 set
// - Status bit 0 shows receive enable
// - Status bit 8 shows transmit enable
// - At zero, reload from next or stop
// - Pointer advances by 1, 2 or 4
// - End flag on reaching zero, buffer flag only if next count is zero too
// - Nonzero counter write clears channel flags unless the counter reaches zero that cycle
`timescale 1ns/1ns
`default_nettype none
`include "peripheral_dma_consts.vh"

module peripheral_dma_unit
(
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Serial peripheral
  input  wire        rxReady,
  input  wire [31:0] rxData,
  output reg         rxTake,
  input  wire        txReady,
  output reg  [31:0] txData,
  output reg         txLoad,
  output wire        rxEndFlag,
  output wire        rxBuffersFullFlag,
  output wire        txEndFlag,
  output wire        txBuffersEmptyFlag,
  // Memory master
  output reg         memReq,
  output reg         memWrite,
  output reg  [31:0] memAddr,
  output reg  [1:0]  memSize,
  output reg  [31:0] memWdata,
  input  wire        memDone,
  input  wire [31:0] memRdata
);

  localparam S_IDLE = 2'd0;
  localparam S_WR   = 2'd1;
  localparam S_RD   = 2'd2;

  // Bus slave state
  reg        dphase_q;
  reg        waited_q;
  reg        wr_q;
  reg [11:0] off_q;

  // Control and configuration
  reg        rxEn_q;
  reg        txEn_q;
  reg        halfDuplex_q;
  reg [1:0]  size_q;

  // Channel storage, index 1 is the transmit set
  reg [31:0] curPtr_q  [0:1];
  reg [15:0] curCnt_q  [0:1];
  reg [31:0] nextPtr_q [0:1];
  reg [15:0] nextCnt_q [0:1];
  reg [1:0]  endFlag_q;
  reg [1:0]  bufFlag_q;

  // Engine
  reg [1:0]  state_q;
  reg        ch_q;

  wire       rxIdx;
  wire       take;
  wire       swWr;
  wire       swRd;
  wire       finish;
  wire [31:0] inc;
  wire       rxGo;
  wire       txGo;

  assign rxIdx = halfDuplex_q;

  assign take  = hsel & hready & htrans[1];
  assign swWr  = dphase_q & ~waited_q & wr_q;
  assign swRd  = dphase_q & ~waited_q & ~wr_q;
  assign hreadyout = ~dphase_q | waited_q;
  assign hresp = 1'b0;

  assign inc = (size_q == `SIZE_WORD) ? 32'h00000004 :
               (size_q == `SIZE_HALF) ? 32'h00000002 : 32'h00000001;

  assign finish = memDone & (state_q != S_IDLE);

  assign rxGo = rxEn_q & (curCnt_q[rxIdx] != 16'h0000) & rxReady;
  assign txGo = txEn_q & (curCnt_q[1] != 16'h0000) & txReady;

  assign rxEndFlag          = endFlag_q[rxIdx];
  assign rxBuffersFullFlag  = bufFlag_q[rxIdx];
  assign txEndFlag          = endFlag_q[1];
  assign txBuffersEmptyFlag = bufFlag_q[1];

  // One wait state on every access keeps hrdata registered
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dphase_q <= 1'b0;
      waited_q <= 1'b0;
      wr_q     <= 1'b0;
      off_q    <= 12'h000;
    end
    else if (hreadyout)
    begin
      dphase_q <= take;
      waited_q <= 1'b0;
      wr_q     <= hwrite;
      off_q    <= haddr[11:0];
    end
    else
    begin
      waited_q <= 1'b1;
    end
  end

  // Read data
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      hrdata <= `RESET_WORD;
    end
    else if (swRd)
    begin
      if (off_q == `OFF_RX_PTR)
        hrdata <= curPtr_q[rxIdx];
      else if (off_q == `OFF_RX_CNT)
        hrdata <= {16'h0000, curCnt_q[rxIdx]};
      else if (off_q == `OFF_TX_PTR)
        hrdata <= curPtr_q[1];
      else if (off_q == `OFF_TX_CNT)
        hrdata <= {16'h0000, curCnt_q[1]};
      else if (off_q == `OFF_RX_NPTR)
        hrdata <= nextPtr_q[rxIdx];
      else if (off_q == `OFF_RX_NCNT)
        hrdata <= {16'h0000, nextCnt_q[rxIdx]};
      else if (off_q == `OFF_TX_NPTR)
        hrdata <= nextPtr_q[1];
      else if (off_q == `OFF_TX_NCNT)
        hrdata <= {16'h0000, nextCnt_q[1]};
      else if (off_q == `OFF_STAT)
        hrdata <= {23'h000000, txEn_q, 7'h00, rxEn_q};
      else if (off_q == `OFF_FLAGS)
        hrdata <= {26'h0000000, bufFlag_q[1], endFlag_q[1], 2'h0,
                   bufFlag_q[rxIdx], endFlag_q[rxIdx]};
      else if (off_q == `OFF_CONFIG)
        hrdata <= {26'h0000000, size_q, 3'h0, halfDuplex_q};
      else
        hrdata <= `RESET_WORD;
    end
  end

  // Enable control and configuration; control is write-only, disables win over enables, but in half duplex bit 0 beats bit 9 for receive
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rxEn_q       <= 1'b0;
      txEn_q       <= 1'b0;
      halfDuplex_q <= 1'b0;
      size_q       <= `SIZE_BYTE;
    end
    else if (swWr && off_q == `OFF_CONFIG)
    begin
      halfDuplex_q <= hwdata[`CFG_HALF_DUPLEX];
      size_q       <= hwdata[`CFG_SIZE_HI:`CFG_SIZE_LO];
    end
    else if (swWr && off_q == `OFF_CTRL)
    begin
      if (hwdata[`CTRL_RX_DIS])
        rxEn_q <= 1'b0;
      else if (hwdata[`CTRL_RX_EN])
        rxEn_q <= 1'b1;
      else if (halfDuplex_q && hwdata[`CTRL_TX_DIS])
        rxEn_q <= 1'b0;
      if (hwdata[`CTRL_TX_DIS])
        txEn_q <= 1'b0;
      else if (halfDuplex_q && (hwdata[`CTRL_RX_EN] || hwdata[`CTRL_RX_DIS]))
        txEn_q <= 1'b0;
      else if (hwdata[`CTRL_TX_EN])
        txEn_q <= 1'b1;
    end
  end

  // Per-channel storage and flags
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_ch
      wire isRx;
      wire isTx;
      wire wPtr;
      wire wCnt;
      wire wNPtr;
      wire wNCnt;
      wire done;
      wire [15:0] left;

      assign isRx  = (rxIdx == c);
      assign isTx  = (c == 1);
      assign wPtr  = swWr & ((off_q == `OFF_RX_PTR & isRx) |
                             (off_q == `OFF_TX_PTR & isTx));
      assign wCnt  = swWr & ((off_q == `OFF_RX_CNT & isRx) |
                             (off_q == `OFF_TX_CNT & isTx));
      assign wNPtr = swWr & ((off_q == `OFF_RX_NPTR & isRx) |
                             (off_q == `OFF_TX_NPTR & isTx));
      assign wNCnt = swWr & ((off_q == `OFF_RX_NCNT & isRx) |
                             (off_q == `OFF_TX_NCNT & isTx));
      assign done  = finish & (ch_q == c);
      assign left  = curCnt_q[c] - 16'h0001;

      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          curPtr_q[c]  <= `RESET_WORD;
          curCnt_q[c]  <= 16'h0000;
          nextPtr_q[c] <= `RESET_WORD;
          nextCnt_q[c] <= 16'h0000;
          endFlag_q[c] <= 1'b0;
          bufFlag_q[c] <= 1'b0;
        end
        else
        begin
          if (done && left == 16'h0000 && nextCnt_q[c] != 16'h0000)
          begin
            curPtr_q[c]  <= nextPtr_q[c];
            curCnt_q[c]  <= nextCnt_q[c];
            nextPtr_q[c] <= `RESET_WORD;
            nextCnt_q[c] <= 16'h0000;
          end
          else if (done)
          begin
            curPtr_q[c] <= curPtr_q[c] + inc;
            curCnt_q[c] <= left;
          end
          // Software write overrides a same-cycle engine update
          // pointer, counter and next register loads
          if (wPtr)
            curPtr_q[c] <= hwdata;
          if (wCnt)
            curCnt_q[c] <= hwdata[15:0];
          if (wNPtr)
            nextPtr_q[c] <= hwdata;
          if (wNCnt)
            nextCnt_q[c] <= hwdata[15:0];
          if (done && left == 16'h0000)
          begin
            endFlag_q[c] <= 1'b1;
            bufFlag_q[c] <= (nextCnt_q[c] == 16'h0000);
          end
          else if ((wCnt || wNCnt) && hwdata[15:0] != 16'h0000)
          begin
            endFlag_q[c] <= 1'b0;
            bufFlag_q[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Transfer engine; receive has priority when both are ready
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= S_IDLE;
      ch_q     <= 1'b0;
      rxTake   <= 1'b0;
      txLoad   <= 1'b0;
      txData   <= `RESET_WORD;
      memReq   <= 1'b0;
      memWrite <= 1'b0;
      memAddr  <= `RESET_WORD;
      memSize  <= `SIZE_BYTE;
      memWdata <= `RESET_WORD;
    end
    else
    begin
      rxTake <= 1'b0;
      txLoad <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (rxGo)
          begin
            state_q  <= S_WR;
            ch_q     <= rxIdx;
            rxTake   <= 1'b1;
            memReq   <= 1'b1;
            memWrite <= 1'b1;
            memAddr  <= curPtr_q[rxIdx];
            memSize  <= size_q;
            memWdata <= rxData;
          end
          else if (txGo)
          begin
            state_q  <= S_RD;
            ch_q     <= 1'b1;
            memReq   <= 1'b1;
            memWrite <= 1'b0;
            memAddr  <= curPtr_q[1];
            memSize  <= size_q;
          end
        end
        S_WR:
        begin
          if (memDone)
          begin
            state_q <= S_IDLE;
            memReq  <= 1'b0;
          end
        end
        S_RD:
        begin
          if (memDone)
          begin
            state_q <= S_IDLE;
            memReq  <= 1'b0;
            txData  <= memRdata;
            txLoad  <= 1'b1;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
          memReq  <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire
